// ===== verilog/msfh_core.sv
/*
 * Motor starter fault handler: applies warning or trip responses to
 * protection events, holds status bits, drives indicator patterns and
 * gates the motor output; registers over classic Wishbone.
 * Assumes one 200 MHz clock and asynchronous detector inputs; power
 * cycling is modelled by rst_i.
 */
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
// Function
// - sensor overload warning: warn bits, flash, autoclear
// - sensor overload trip: fault bits, refuse hot ack
// - sensor short/break: own bit, warn or trip
// - model overload warning: warn bits, autoclear after cooling
// - model trip: cooling bit, ack after cooling
// - self-test fault trips, cleared only by power
// - switching element defect trips, power cycle clears
// - duo overvoltage trips, trip reset clears
// - duo line protection trips, trip reset clears
// - auto-acknowledged faults clear when cause disappears
// - trip with restart restarts if start pending
module msfh_core #(
    parameter int FLASH_HALF = msfh_pkg::FLASH_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic ts_ovl_i,
    input wire logic ts_short_i,
    input wire logic ts_break_i,
    input wire logic ts_cool_i,
    input wire logic tm_ovl_i,
    input wire logic tm_cool_i,
    input wire logic selftest_i,
    input wire logic sw_def_i,
    input wire logic icv_high_i,
    input wire logic line_prot_i,
    input wire logic [7:0] cool_status_i,
    output logic motor_on_o,
    output logic [1:0] group_fault_indicator_o,
    output logic [1:0] device_led_o,
    output logic [1:0] state_led_o,
    output logic irq_o
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [msfh_pkg::ST_W-1:0] st;
        logic [msfh_pkg::EV_W-1:0] ev;
        logic [msfh_pkg::EV_W-1:0] mask;
        logic [7:0] cool;
        logic [1:0] gf_led;
        logic [1:0] dev_led;
        logic [1:0] state_led;
        logic [31:0] flash_cnt;
        logic flash;
        logic motor;
        logic irq;
        logic ack;
        logic [31:0] rdata;
    } msfh_state_t;
    msfh_state_t state_reg, state_next;

    msfh_sync_if s_if();
    msfh_sync #(
        .W(10)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({line_prot_i, icv_high_i, sw_def_i, selftest_i, tm_cool_i, tm_ovl_i, ts_cool_i,
            ts_break_i, ts_short_i, ts_ovl_i}),
        .sync_o(s_if)
    );

    logic [1:0] ts_resp, tsl_resp, tm_resp;
    logic duo, start_cmd, req, wr, rd, trip_rst;
    logic [msfh_pkg::ST_W-1:0] st;
    logic any_trip, any_warn, hot_trip;
    logic [31:0] rd_mux;
    logic [1:0] dev_c, gf_c, state_c;
    logic [msfh_pkg::EV_W-1:0] ev_set;

    always_comb begin
        state_next = state_reg;
        ts_resp = state_reg.ctrl[msfh_pkg::CTRL_TS_RESP_LSB +: 2];
        tsl_resp = state_reg.ctrl[msfh_pkg::CTRL_TSL_RESP_LSB +: 2];
        tm_resp = state_reg.ctrl[msfh_pkg::CTRL_TM_RESP_LSB +: 2];
        start_cmd = state_reg.ctrl[msfh_pkg::CTRL_START_BIT];
        duo = state_reg.ctrl[msfh_pkg::CTRL_DUO_BIT];
        req = cyc_i && stb_i && !state_reg.ack;
        wr = req && we_i;
        rd = req && !we_i;
        trip_rst = wr && adr_i == msfh_pkg::ADDR_CMD && sel_i[0] && dat_i[msfh_pkg::CMD_TRIP_RESET_BIT];
        st = state_reg.st;

        // sensor warnings follow their causes directly; the model warning also holds until the model is cool
        st[msfh_pkg::ST_GEN_WARN] = 1'b0;
        if (ts_resp == msfh_pkg::RESP_WARN) begin
            st[msfh_pkg::ST_TS_OVL] = s_if.ts_ovl;
        end
        if (tsl_resp == msfh_pkg::RESP_WARN) begin
            st[msfh_pkg::ST_TS_SHORT] = s_if.ts_short;
            st[msfh_pkg::ST_TS_BREAK] = s_if.ts_break;
        end
        if (tm_resp == msfh_pkg::RESP_WARN) begin
            st[msfh_pkg::ST_TM_OVL] = s_if.tm_ovl || !s_if.tm_cool;
        end
        // trips latch until acknowledged; self-test and switching defect latch until power
        if (ts_resp != msfh_pkg::RESP_WARN && s_if.ts_ovl) begin
            st[msfh_pkg::ST_TS_OVL] = 1'b1;
            st[msfh_pkg::ST_OVL_TRIP] = 1'b1;
        end
        if (tsl_resp != msfh_pkg::RESP_WARN && (s_if.ts_short || s_if.ts_break)) begin
            st[msfh_pkg::ST_TS_SHORT] = st[msfh_pkg::ST_TS_SHORT] | s_if.ts_short;
            st[msfh_pkg::ST_TS_BREAK] = st[msfh_pkg::ST_TS_BREAK] | s_if.ts_break;
            st[msfh_pkg::ST_OVL_TRIP] = 1'b1;
        end
        if (tm_resp != msfh_pkg::RESP_WARN && s_if.tm_ovl) begin
            st[msfh_pkg::ST_TM_OVL] = 1'b1;
            st[msfh_pkg::ST_OVL_TRIP] = 1'b1;
        end
        if (tm_resp != msfh_pkg::RESP_WARN) begin
            st[msfh_pkg::ST_COOL_ACT] = st[msfh_pkg::ST_TM_OVL] && !s_if.tm_cool;
        end else begin
            st[msfh_pkg::ST_COOL_ACT] = 1'b0;
        end
        st[msfh_pkg::ST_SELFTEST] = st[msfh_pkg::ST_SELFTEST] | s_if.selftest;
        st[msfh_pkg::ST_SW_DEF] = st[msfh_pkg::ST_SW_DEF] | s_if.sw_def;
        if (duo) begin
            st[msfh_pkg::ST_ICV_HIGH] = st[msfh_pkg::ST_ICV_HIGH] | s_if.icv_high;
            st[msfh_pkg::ST_LINE_OVL] = st[msfh_pkg::ST_LINE_OVL] | s_if.line_prot;
            st[msfh_pkg::ST_LINE_TRIP] = st[msfh_pkg::ST_LINE_TRIP] | s_if.line_prot;
        end

        // hot overload trips refuse acknowledgement while cause or heat remains
        hot_trip = (ts_resp != msfh_pkg::RESP_WARN && (s_if.ts_ovl || !s_if.ts_cool))
            || (tsl_resp != msfh_pkg::RESP_WARN && (s_if.ts_short || s_if.ts_break))
            || (tm_resp != msfh_pkg::RESP_WARN && (s_if.tm_ovl || !s_if.tm_cool));
        if (st[msfh_pkg::ST_OVL_TRIP] && !hot_trip) begin
            // trip reset clears; with restart the device clears on its own
            if (trip_rst || (ts_resp == msfh_pkg::RESP_TRIP_RESTART && st[msfh_pkg::ST_TS_OVL])
                || (tsl_resp == msfh_pkg::RESP_TRIP_RESTART
                    && (st[msfh_pkg::ST_TS_SHORT] || st[msfh_pkg::ST_TS_BREAK]))
                || (tm_resp == msfh_pkg::RESP_TRIP_RESTART && st[msfh_pkg::ST_TM_OVL])) begin
                st[msfh_pkg::ST_OVL_TRIP] = 1'b0;
                if (ts_resp != msfh_pkg::RESP_WARN) st[msfh_pkg::ST_TS_OVL] = 1'b0;
                if (tsl_resp != msfh_pkg::RESP_WARN) begin
                    st[msfh_pkg::ST_TS_SHORT] = 1'b0;
                    st[msfh_pkg::ST_TS_BREAK] = 1'b0;
                end
                if (tm_resp != msfh_pkg::RESP_WARN) st[msfh_pkg::ST_TM_OVL] = 1'b0;
            end
        end
        if (trip_rst && !s_if.icv_high) st[msfh_pkg::ST_ICV_HIGH] = 1'b0;
        if (trip_rst && !s_if.line_prot) begin
            st[msfh_pkg::ST_LINE_OVL] = 1'b0;
            st[msfh_pkg::ST_LINE_TRIP] = 1'b0;
        end

        any_trip = st[msfh_pkg::ST_OVL_TRIP] | st[msfh_pkg::ST_SELFTEST] | st[msfh_pkg::ST_SW_DEF]
            | st[msfh_pkg::ST_ICV_HIGH] | st[msfh_pkg::ST_LINE_TRIP];
        any_warn = (ts_resp == msfh_pkg::RESP_WARN && st[msfh_pkg::ST_TS_OVL])
            || (tsl_resp == msfh_pkg::RESP_WARN && (st[msfh_pkg::ST_TS_SHORT] || st[msfh_pkg::ST_TS_BREAK]))
            || (tm_resp == msfh_pkg::RESP_WARN && st[msfh_pkg::ST_TM_OVL]);
        st[msfh_pkg::ST_GEN_FAULT] = any_trip;
        st[msfh_pkg::ST_GEN_WARN] = any_warn;
        st[msfh_pkg::ST_MOTOR_ON] = start_cmd && !any_trip;
        state_next.st = st;
        state_next.motor = start_cmd && !any_trip;

        // indicators: worst condition wins
        gf_c = any_trip ? msfh_pkg::LED_RED : msfh_pkg::LED_OFF;
        state_c = st[msfh_pkg::ST_SW_DEF] ? msfh_pkg::LED_RED : msfh_pkg::LED_OFF;
        if (st[msfh_pkg::ST_SELFTEST] || st[msfh_pkg::ST_SW_DEF]) begin
            dev_c = msfh_pkg::LED_RED;
        end else if (any_trip) begin
            dev_c = msfh_pkg::LED_YELLOW;
        end else if (any_warn) begin
            dev_c = state_reg.flash ? msfh_pkg::LED_YELLOW : msfh_pkg::LED_OFF;
        end else begin
            dev_c = msfh_pkg::LED_OFF;
        end
        state_next.gf_led = gf_c;
        state_next.dev_led = dev_c;
        state_next.state_led = state_c;
        if (state_reg.flash_cnt >= 32'(FLASH_HALF - 1)) begin
            state_next.flash_cnt = '0;
            state_next.flash = !state_reg.flash;
        end else begin
            state_next.flash_cnt = state_reg.flash_cnt + 32'h1;
        end
        state_next.cool = cool_status_i;

        // interrupt events: set wins over the clear by read
        ev_set = '0;
        ev_set[msfh_pkg::EV_TRIP] = any_trip && !state_reg.st[msfh_pkg::ST_GEN_FAULT];
        ev_set[msfh_pkg::EV_WARN] = any_warn && !state_reg.st[msfh_pkg::ST_GEN_WARN];
        ev_set[msfh_pkg::EV_CLEAR] = !any_trip && state_reg.st[msfh_pkg::ST_GEN_FAULT];
        state_next.ev = ((rd && adr_i == msfh_pkg::ADDR_IRQ_STAT) ? '0 : state_reg.ev) | ev_set;
        state_next.irq = |(state_next.ev & state_reg.mask);

        // register writes
        if (wr && adr_i == msfh_pkg::ADDR_CTRL) begin
            for (int b = 0; b < 4; b++) begin
                if (sel_i[b]) state_next.ctrl[b*8 +: 8] = dat_i[b*8 +: 8];
            end
        end
        if (wr && adr_i == msfh_pkg::ADDR_IRQ_MASK && sel_i[0]) begin
            state_next.mask = dat_i[msfh_pkg::EV_W-1:0];
        end
        rd_mux = '0;
        unique case (adr_i)
            msfh_pkg::ADDR_CTRL: rd_mux = state_reg.ctrl;
            msfh_pkg::ADDR_STAT: rd_mux = 32'(state_reg.st);
            msfh_pkg::ADDR_IRQ_STAT: rd_mux = 32'(state_reg.ev);
            msfh_pkg::ADDR_IRQ_MASK: rd_mux = 32'(state_reg.mask);
            msfh_pkg::ADDR_LED: rd_mux = {26'h0, state_reg.state_led, state_reg.dev_led, state_reg.gf_led};
            msfh_pkg::ADDR_MEAS: rd_mux = {24'h0, state_reg.cool};
            default: rd_mux = '0;
        endcase
        state_next.rdata = rd ? rd_mux : state_reg.rdata;
        state_next.ack = req;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.ctrl <= msfh_pkg::CTRL_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign dat_o = state_reg.rdata;
    assign ack_o = state_reg.ack;
    assign motor_on_o = state_reg.motor;
    assign group_fault_indicator_o = state_reg.gf_led;
    assign device_led_o = state_reg.dev_led;
    assign state_led_o = state_reg.state_led;
    assign irq_o = state_reg.irq;
endmodule // msfh_core
`default_nettype wire

// ===== verilog/msfh_pkg.sv
/*
 * Package for the motor starter fault handler: register offsets, field
 * positions, response codes, indicator colours, reset values and timing.
 * Assumes a Wishbone slave with 32-bit data and byte addresses.
 */
`default_nettype none
package msfh_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
    localparam logic [7:0] ADDR_LED = 8'h14;
    localparam logic [7:0] ADDR_MEAS = 8'h18;

    // response to a protection event
    localparam logic [1:0] RESP_TRIP = 2'h0;
    localparam logic [1:0] RESP_TRIP_RESTART = 2'h1;
    localparam logic [1:0] RESP_WARN = 2'h2;

    // control register fields
    localparam int CTRL_TS_RESP_LSB = 0;
    localparam int CTRL_TSL_RESP_LSB = 2;
    localparam int CTRL_TM_RESP_LSB = 4;
    localparam int CTRL_START_BIT = 8;
    localparam int CTRL_DUO_BIT = 9;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // command register bits (write-only pulses)
    localparam int CMD_TRIP_RESET_BIT = 0;

    // status bit positions
    localparam int ST_GEN_WARN = 0;
    localparam int ST_GEN_FAULT = 1;
    localparam int ST_TS_OVL = 2;
    localparam int ST_TS_SHORT = 3;
    localparam int ST_TS_BREAK = 4;
    localparam int ST_TM_OVL = 5;
    localparam int ST_OVL_TRIP = 6;
    localparam int ST_COOL_ACT = 7;
    localparam int ST_SELFTEST = 8;
    localparam int ST_SW_DEF = 9;
    localparam int ST_ICV_HIGH = 10;
    localparam int ST_LINE_OVL = 11;
    localparam int ST_LINE_TRIP = 12;
    localparam int ST_MOTOR_ON = 13;
    localparam int ST_W = 14;

    // event bits of the interrupt status register
    localparam int EV_TRIP = 0;
    localparam int EV_WARN = 1;
    localparam int EV_CLEAR = 2;
    localparam int EV_W = 3;

    // indicator colours
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_RED = 2'h1;
    localparam logic [1:0] LED_YELLOW = 2'h2;
    localparam logic [1:0] LED_YEL_FLASH = 2'h3;
    localparam int LED_GF_LSB = 0;
    localparam int LED_DEV_LSB = 2;
    localparam int LED_STATE_LSB = 4;

    // flash half period for the device indicator
    localparam int CLK_MHZ = 200;
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;
endpackage
`default_nettype wire

// ===== verilog/msfh_sync_if.sv
/*
 * Interface carrying the protection inputs between the synchroniser and
 * the fault handler core. Assumes a single clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface msfh_sync_if;
    logic ts_ovl;
    logic ts_short;
    logic ts_break;
    logic ts_cool;
    logic tm_ovl;
    logic tm_cool;
    logic selftest;
    logic sw_def;
    logic icv_high;
    logic line_prot;
    modport src (output ts_ovl, ts_short, ts_break, ts_cool, tm_ovl, tm_cool, selftest, sw_def,
        icv_high, line_prot);
    modport dst (input ts_ovl, ts_short, ts_break, ts_cool, tm_ovl, tm_cool, selftest, sw_def,
        icv_high, line_prot);
endinterface
`default_nettype wire

// ===== verilog/msfh_sync.sv
/*
 * Two-flop synchroniser for the protection detector inputs.
 * Assumes inputs are asynchronous levels; output lags by two edges.
 */
`timescale 1ns/10ps
`default_nettype none
module msfh_sync #(
    parameter int W = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    msfh_sync_if.src sync_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } msfh_sync_state_t;
    msfh_sync_state_t state_reg, state_next;

    always_comb begin
        state_next.meta = async_i;
        state_next.sync = state_reg.meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign {sync_o.line_prot, sync_o.icv_high, sync_o.sw_def, sync_o.selftest, sync_o.tm_cool,
        sync_o.tm_ovl, sync_o.ts_cool, sync_o.ts_break, sync_o.ts_short, sync_o.ts_ovl} = state_reg.sync;
endmodule // msfh_sync
`default_nettype wire

// ===== sim/msfh_core_sva.sv
/*
 * Checker bound to msfh_core: bus handshake, latched device faults, motor gating.
 * Assumes the single clock and the synchronous active-high reset of the core.
 */
`timescale 1ns/10ps
`default_nettype none
module msfh_core_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic selftest_i,
    input wire logic sw_def_i,
    input wire logic motor_on_o,
    input wire logic [1:0] group_fault_indicator_o,
    input wire logic [1:0] device_led_o,
    input wire logic [1:0] state_led_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_one: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    chk_ack_timely: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack after request");
    chk_ack_idle: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
    chk_unmapped_zero: assert property (cyc_i && stb_i && !we_i && !ack_o && adr_i == 8'h1C |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_selftest_red: assert property (selftest_i [*4] |=> device_led_o == msfh_pkg::LED_RED
        && group_fault_indicator_o == msfh_pkg::LED_RED) else $error("self-test fault not red");
    chk_swdef_red: assert property (sw_def_i [*4] |=> state_led_o == msfh_pkg::LED_RED
        && device_led_o == msfh_pkg::LED_RED) else $error("switch defect not red");
    chk_power_only: assert property (device_led_o == msfh_pkg::LED_RED |=>
        device_led_o == msfh_pkg::LED_RED) else $error("device fault cleared without reset");
    chk_trip_motor: assert property (group_fault_indicator_o == msfh_pkg::LED_RED |-> !motor_on_o)
        else $error("motor on during trip");
endmodule // msfh_core_sva
bind msfh_core msfh_core_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .selftest_i(selftest_i), .sw_def_i(sw_def_i),
    .motor_on_o(motor_on_o), .group_fault_indicator_o(group_fault_indicator_o), .device_led_o(device_led_o),
    .state_led_o(state_led_o));
`default_nettype wire

// ===== sim/msfh_fb_master.sv
/*
 * Controller model: classic Wishbone single-cycle master issuing commands.
 * Assumes a slave that answers with a one-cycle ack.
 */
`timescale 1ns/10ps
`default_nettype none
module msfh_fb_master (
    input wire logic clk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        // released data no longer shows the last value
        dat_o <= ~d;
    endtask
endmodule // msfh_fb_master
`default_nettype wire

// ===== sim/testbench.sv
/*
 * Testbench for msfh_core: bus cases, a table of fault rows, then trip reset, hot refusal and interrupt cases.
 * Assumes the controller model and the bound checker.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    typedef struct {logic [31:0] ctrl; logic [7:0] flt; logic [31:0] st; logic [1:0] gf; logic [1:0] dev;
        logic [1:0] sl; logic f2; logic m2;} msfh_row_t;
    msfh_row_t rows [11] = '{
        '{32'h2, 8'h01, 32'h5, 2'h0, 2'h3, 2'h0, 1'h0, 1'h0}, '{32'h0, 8'h01, 32'h46, 2'h1, 2'h2, 2'h0, 1'h1, 1'h0},
        '{32'h8, 8'h02, 32'h9, 2'h0, 2'h3, 2'h0, 1'h0, 1'h0}, '{32'h0, 8'h04, 32'h52, 2'h1, 2'h2, 2'h0, 1'h1, 1'h0},
        '{32'h20, 8'h08, 32'h21, 2'h0, 2'h3, 2'h0, 1'h0, 1'h0}, '{32'h0, 8'h08, 32'hE2, 2'h1, 2'h2, 2'h0, 1'h1, 1'h0},
        '{32'h0, 8'h10, 32'h102, 2'h1, 2'h1, 2'h0, 1'h1, 1'h0}, '{32'h0, 8'h20, 32'h202, 2'h1, 2'h1, 2'h1, 1'h1, 1'h0},
        '{32'h200, 8'h40, 32'h402, 2'h1, 2'h2, 2'h0, 1'h1, 1'h0},
        '{32'h200, 8'h80, 32'h1802, 2'h1, 2'h2, 2'h0, 1'h1, 1'h0},
        '{32'h101, 8'h01, 32'h46, 2'h1, 2'h2, 2'h0, 1'h0, 1'h1}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] flt = 8'h00;
    logic ts_cool = 1'b1;
    logic tm_cool = 1'b1;
    logic cyc, stb, we, ack, motor, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [1:0] gf, dev, sl;
    int error_cnt = 0;
    int n_checks = 0;
    logic ok_all, seen_y, seen_o;
    always #2.5 clk_i = ~clk_i;
    msfh_core #(.FLASH_HALF(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .ts_ovl_i(flt[0]),
        .ts_short_i(flt[1]), .ts_break_i(flt[2]), .ts_cool_i(ts_cool), .tm_ovl_i(flt[3]), .tm_cool_i(tm_cool),
        .selftest_i(flt[4]), .sw_def_i(flt[5]), .icv_high_i(flt[6]), .line_prot_i(flt[7]),
        .cool_status_i(8'hA5), .motor_on_o(motor), .group_fault_indicator_o(gf), .device_led_o(dev),
        .state_led_o(sl), .irq_o(irq));
    msfh_fb_master fb (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
        .adr_o(adr), .sel_o(sel), .dat_o(wdat));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        fb.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
        logic [31:0] q;
        fb.xfer(1'b0, a, 32'h0, q);
        chk(q & m, e);
        #1;
    endtask
    task automatic pwr();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    task automatic fault(input logic [7:0] f, input logic c);
        @(posedge clk_i);
        flt <= f;
        ts_cool <= c;
        tm_cool <= c;
        wt(6);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        chk({motor, gf, dev, sl, irq}, 8'h00);
        rd(msfh_pkg::ADDR_CTRL, msfh_pkg::CTRL_RESET);
        wr(msfh_pkg::ADDR_CTRL, 32'h32A);
        rd(msfh_pkg::ADDR_CTRL, 32'h32A);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0);
        rd(msfh_pkg::ADDR_MEAS, 32'hA5);
        $display("test bus done");
        foreach (rows[i]) begin
            pwr();
            wr(msfh_pkg::ADDR_CTRL, rows[i].ctrl);
            fault(rows[i].flt, 1'b0);
            rd(msfh_pkg::ADDR_STAT, rows[i].st);
            chk({gf, sl, motor}, {rows[i].gf, rows[i].sl, 1'b0});
            // watch two flash half periods: a flashing indicator must show both yellow and off
            ok_all = 1'b1;
            seen_y = 1'b0;
            seen_o = 1'b0;
            repeat (8) begin
                wt(1);
                ok_all &= rows[i].dev == 2'h3 ? (dev === 2'h2 || dev === 2'h0) : dev === rows[i].dev;
                seen_y |= dev === 2'h2;
                seen_o |= dev === 2'h0;
            end
            chk({ok_all, seen_y, seen_o}, {1'b1, rows[i].dev[1], rows[i].dev == 2'h3});
            fault(8'h00, 1'b1);
            wt(2);
            rd(msfh_pkg::ADDR_STAT, {30'h0, rows[i].f2, 1'b0}, 32'h3);
            chk(motor, rows[i].m2);
            $display("row %0d done", i);
        end
        pwr();
        fault(8'hC0, 1'b1);
        rd(msfh_pkg::ADDR_STAT, 32'h0);
        wr(msfh_pkg::ADDR_CTRL, 32'h200);
        wt(6);
        wr(msfh_pkg::ADDR_CMD, 32'h1);
        rd(msfh_pkg::ADDR_STAT, 32'h2, 32'h2);
        fault(8'h00, 1'b1);
        wr(msfh_pkg::ADDR_CMD, 32'h1);
        wt(4);
        rd(msfh_pkg::ADDR_STAT, 32'h0);
        $display("test trip reset done");
        pwr();
        wr(msfh_pkg::ADDR_CTRL, 32'h100);
        wt(4);
        chk(motor, 1'b1);
        fault(8'h01, 1'b0);
        wr(msfh_pkg::ADDR_CTRL, 32'h100);
        wt(4);
        chk(motor, 1'b0);
        fault(8'h00, 1'b0);
        wr(msfh_pkg::ADDR_CMD, 32'h1);
        wt(4);
        rd(msfh_pkg::ADDR_STAT, 32'h2, 32'h2);
        fault(8'h00, 1'b1);
        wr(msfh_pkg::ADDR_CMD, 32'h1);
        wt(4);
        rd(msfh_pkg::ADDR_STAT, 32'h2000);
        chk(motor, 1'b1);
        $display("test hot refusal done");
        pwr();
        fault(8'h01, 1'b0);
        chk(irq, 1'b0);
        wr(msfh_pkg::ADDR_IRQ_MASK, 32'h1);
        wt(2);
        chk(irq, 1'b1);
        rd(msfh_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1);
        wt(2);
        chk(irq, 1'b0);
        $display("test irq done");
        report_and_stop();
    end
endmodule // testbench
`default_nettype wire
